// *** xmrc_ctrl.v ***
// xip mode entry, exit, power-up and rescue controller
`timescale 1ns/1ps
`include "xmrc_consts.vh"
module xmrc_ctrl #(
  parameter integer PWRUP_CYCLES = `XMRC_PWRUP_US * `XMRC_CLK_MHZ
) (
  input wire core_clk,
  input wire rst_n,
  input wire chip_select_n,
  input wire serial_clk,
  input wire serial_data_0,
  input wire serial_data_1,
  input wire serial_data_2,
  input wire hold_data_3,
  input wire hardware_reset_n,
  input wire reset_pin_enable,
  input wire basic_xip_variant,
  input wire [2:0] nv_xip_sel,
  input wire [1:0] nv_protocol_sel,
  input wire vcr_wr_strobe,
  input wire vcr_wr_xip_n,
  input wire fast_read_active,
  input wire first_dummy_cycle,
  output wire xip_active,
  output wire addr_only_mode,
  output wire [1:0] protocol,
  output wire vcr_xip_n,
  output wire xip_confirm_bit,
  output wire device_ready,
  output wire status_reads_only,
  output wire status_init_pulse,
  output wire frame_sclk_rise
);

  // ------------------------------------------------------------
  // states and derived constants
  // ------------------------------------------------------------
  localparam [1:0] ST_LOAD = 2'h0;
  localparam [1:0] ST_PWRUP = 2'h1;
  localparam [1:0] ST_STANDBY = 2'h2;

  localparam [15:0] PWRUP_LAST = PWRUP_CYCLES[15:0] - 16'h0001;

  // rescue progress: bursts seen so far in the expected order
  localparam [1:0] RS_IDLE = 2'h0;
  localparam [1:0] RS_GOT7 = 2'h1;
  localparam [1:0] RS_GOT13 = 2'h2;
  localparam [1:0] RS_GOT25 = 2'h3;

  wire cs_n_s;
  wire sclk_s;
  wire d0_s;
  wire d3_s;
  wire rst_pin_n_s;
  wire sclk_rise;
  wire frame_end;
  wire [4:0] frame_cnt;
  wire d0_high;
  wire d03_high;
  wire gap_ok;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] pwrup_cnt_q;
  reg [15:0] pwrup_cnt_d;
  reg pwrup_done_q;
  reg pwrup_done_d;
  reg xip_q;
  reg xip_d;
  reg [1:0] proto_q;
  reg [1:0] proto_d;
  reg vcr_xip_n_q;
  reg vcr_xip_n_d;
  reg confirm_q;
  reg confirm_d;
  reg [1:0] rescue_q;
  reg [1:0] rescue_d;
  reg ready_q;
  reg init_pulse_q;
  reg [4:0] exit_len;
  reg pin_reset;
  reg xip_enabled;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // data lines 1 and 2 feed no logic here: on the first dummy clock
  // only serial_data_0 counts, the rest are don't care
  xmrc_sync #(.W(1), .INIT(1'b1)) u_sync_hi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(chip_select_n),
    .sync_out(cs_n_s)
  );

  xmrc_sync #(.W(1), .INIT(1'b1)) u_sync_rst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(hardware_reset_n),
    .sync_out(rst_pin_n_s)
  );

  xmrc_sync #(.W(3), .INIT(1'b0)) u_sync_lo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({serial_clk, serial_data_0, hold_data_3}),
    .sync_out({sclk_s, d0_s, d3_s})
  );

  // ------------------------------------------------------------
  // frame monitor
  // ------------------------------------------------------------
  xmrc_frame_mon u_mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cs_n_s(cs_n_s),
    .sclk_s(sclk_s),
    .d0_s(d0_s),
    .d3_s(d3_s),
    .sclk_rise(sclk_rise),
    .frame_end_q(frame_end),
    .count_q(frame_cnt),
    .d0_high_q(d0_high),
    .d03_high_q(d03_high),
    .gap_ok_q(gap_ok)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // exit burst length follows the protocol in use
  always @* begin
    case (proto_q)
      `XMRC_PROTO_QUAD: exit_len = `XMRC_EXIT_QUAD;
      `XMRC_PROTO_DUAL: exit_len = `XMRC_EXIT_DUAL;
      default: exit_len = `XMRC_EXIT_EXT;
    endcase
  end

  // reset pin honoured only while deselected, and only if enabled
  always @* begin
    pin_reset = reset_pin_enable & ~rst_pin_n_s & cs_n_s;
    xip_enabled = ~vcr_xip_n_q | basic_xip_variant;
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    pwrup_cnt_d = pwrup_cnt_q;
    pwrup_done_d = pwrup_done_q;
    xip_d = xip_q;
    proto_d = proto_q;
    vcr_xip_n_d = vcr_xip_n_q;
    confirm_d = confirm_q;
    rescue_d = rescue_q;
    case (state_q)
      ST_LOAD: begin
        // straps read a cycle after release; a held pin reset reloads the protocol strap every cycle
        if (nv_xip_sel != `XMRC_NV_XIP_OFF) begin
          xip_d = 1'b1;
          confirm_d = 1'b0;
        end else begin
          xip_d = 1'b0;
          confirm_d = `XMRC_CONFIRM_RST;
        end
        proto_d = nv_protocol_sel;
        vcr_xip_n_d = `XMRC_VCR_XIP_RST;
        rescue_d = RS_IDLE;
        // a pin reset skips the supply delay already served
        if (pwrup_done_q) begin
          state_d = ST_STANDBY;
        end else begin
          state_d = ST_PWRUP;
        end
      end
      ST_PWRUP: begin
        // only status reads are served while this counts
        if (pwrup_cnt_q == PWRUP_LAST) begin
          pwrup_done_d = 1'b1;
          state_d = ST_STANDBY;
        end else begin
          pwrup_cnt_d = pwrup_cnt_q + 16'h0001;
        end
      end
      ST_STANDBY: begin
        // software write of the volatile enable bit
        if (vcr_wr_strobe) begin
          vcr_xip_n_d = vcr_wr_xip_n;
        end
        // confirm bit on the first dummy clock of a fast read
        if (sclk_rise && fast_read_active && first_dummy_cycle) begin
          if (!d0_s) begin
            if (xip_enabled || xip_q) begin
              xip_d = 1'b1;
              confirm_d = 1'b0;
            end
          end else begin
            // hardware restore wins over a write in the same cycle
            xip_d = 1'b0;
            confirm_d = 1'b1;
            vcr_xip_n_d = 1'b1;
          end
        end
        // frame-end checks: forced exit and rescue sequence
        if (frame_end) begin
          // forced exit leaves program and erase state alone
          if (xip_q && d0_high && frame_cnt == exit_len) begin
            xip_d = 1'b0;
            confirm_d = 1'b1;
            vcr_xip_n_d = 1'b1;
          end
          if (!d03_high) begin
            rescue_d = RS_IDLE;
          end else begin
            case (rescue_q)
              RS_IDLE: begin
                if (frame_cnt == `XMRC_EXIT_QUAD) begin
                  rescue_d = RS_GOT7;
                end
              end
              RS_GOT7: begin
                if (gap_ok && frame_cnt == `XMRC_EXIT_DUAL) begin
                  rescue_d = RS_GOT13;
                end else if (frame_cnt == `XMRC_EXIT_QUAD) begin
                  rescue_d = RS_GOT7;
                end else begin
                  rescue_d = RS_IDLE;
                end
              end
              RS_GOT13: begin
                if (gap_ok && frame_cnt == `XMRC_EXIT_EXT) begin
                  rescue_d = RS_GOT25;
                end else if (frame_cnt == `XMRC_EXIT_QUAD) begin
                  rescue_d = RS_GOT7;
                end else begin
                  rescue_d = RS_IDLE;
                end
              end
              RS_GOT25: begin
                if (gap_ok && frame_cnt == `XMRC_RESCUE_TAIL) begin
                  // part two done: fixed extended spi, no xip
                  proto_d = `XMRC_PROTO_EXT;
                  xip_d = 1'b0;
                  confirm_d = 1'b1;
                  vcr_xip_n_d = 1'b1;
                  rescue_d = RS_IDLE;
                end else if (frame_cnt == `XMRC_EXIT_QUAD) begin
                  rescue_d = RS_GOT7;
                end else begin
                  rescue_d = RS_IDLE;
                end
              end
              default: rescue_d = RS_IDLE;
            endcase
          end
        end
      end
      default: state_d = ST_LOAD;
    endcase
    // pin reset clears xip first; the load state reloads the straps
    if (pin_reset) begin
      state_d = ST_LOAD;
      xip_d = 1'b0;
      // volatile bit and confirm go idle with xip, never left stale
      vcr_xip_n_d = `XMRC_VCR_XIP_RST;
      confirm_d = `XMRC_CONFIRM_RST;
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  // power-on reset holds every flop at its idle value
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_LOAD;
      pwrup_cnt_q <= 16'h0000;
      pwrup_done_q <= 1'b0;
      xip_q <= 1'b0;
      proto_q <= `XMRC_PROTO_EXT;
      vcr_xip_n_q <= `XMRC_VCR_XIP_RST;
      confirm_q <= `XMRC_CONFIRM_RST;
      rescue_q <= RS_IDLE;
      ready_q <= 1'b0;
      init_pulse_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pwrup_cnt_q <= pwrup_cnt_d;
      pwrup_done_q <= pwrup_done_d;
      xip_q <= xip_d;
      proto_q <= proto_d;
      vcr_xip_n_q <= vcr_xip_n_d;
      confirm_q <= confirm_d;
      rescue_q <= rescue_d;
      ready_q <= (state_d == ST_STANDBY);
      // one pulse on entry to standby clears latch, busy and locks
      init_pulse_q <= (state_d == ST_STANDBY) &&
                      (state_q != ST_STANDBY);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign xip_active = xip_q;
  assign addr_only_mode = xip_q;
  assign protocol = proto_q;
  assign vcr_xip_n = vcr_xip_n_q;
  assign xip_confirm_bit = confirm_q;
  assign device_ready = ready_q;
  assign status_reads_only = ~ready_q;
  assign status_init_pulse = init_pulse_q;
  assign frame_sclk_rise = sclk_rise;

endmodule

// *** xmrc_consts.vh ***
// constants for the xip mode and recovery controller
`ifndef XMRC_CONSTS_VH
`define XMRC_CONSTS_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define XMRC_CLK_MHZ 100
`define XMRC_CLK_NS 10
`define XMRC_PWRUP_US 150
`define XMRC_GAP_NS 50

// ------------------------------------------------------------
// protocol codes and burst lengths
// ------------------------------------------------------------
`define XMRC_PROTO_EXT 2'h0
`define XMRC_PROTO_DUAL 2'h1
`define XMRC_PROTO_QUAD 2'h2
`define XMRC_EXIT_QUAD 5'h07
`define XMRC_EXIT_DUAL 5'h0d
`define XMRC_EXIT_EXT 5'h19
`define XMRC_RESCUE_TAIL 5'h08
`define XMRC_CNT_MAX 5'h1f

// ------------------------------------------------------------
// configuration fields and reset values
// ------------------------------------------------------------
`define XMRC_NV_XIP_OFF 3'h7
`define XMRC_VCR_XIP_RST 1'b1
`define XMRC_CONFIRM_RST 1'b1

`endif

// *** xmrc_sync.v ***
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module xmrc_sync #(
  parameter W = 1,
  parameter [0:0] INIT = 1'b0
) (
  input wire core_clk,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;

  // ------------------------------------------------------------
  // per-bit stages
  // ------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      // first stage feeds only the second; change taken when 2 and 3 agree
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= INIT;
          s2_q <= INIT;
          s3_q <= INIT;
          out_q <= INIT;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign sync_out[i] = out_q;
    end
  endgenerate

endmodule

// *** xmrc_frame_mon.v ***
// frame monitor: clock edges, held data lines and deselect gap
`timescale 1ns/1ps
`include "xmrc_consts.vh"
module xmrc_frame_mon (
  input wire core_clk,
  input wire rst_n,
  input wire cs_n_s,
  input wire sclk_s,
  input wire d0_s,
  input wire d3_s,
  output wire sclk_rise,
  output reg frame_end_q,
  output reg [4:0] count_q,
  output reg d0_high_q,
  output reg d03_high_q,
  output reg gap_ok_q
);

  // gap in core cycles, a least time so rounded up
  localparam integer GAP_INT =
    (`XMRC_GAP_NS + `XMRC_CLK_NS - 1) / `XMRC_CLK_NS;
  localparam [4:0] GAP_CYC = GAP_INT[4:0];

  reg sclk_prev_q;
  reg cs_prev_q;
  reg [4:0] gap_q;

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;

  // ------------------------------------------------------------
  // edge and frame tracking
  // ------------------------------------------------------------
  // flags held after frame end so the controller reads them late
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      frame_end_q <= 1'b0;
      count_q <= 5'h00;
      d0_high_q <= 1'b0;
      d03_high_q <= 1'b0;
      gap_q <= 5'h00;
      gap_ok_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
      frame_end_q <= cs_n_s & ~cs_prev_q;
      if (!cs_n_s && cs_prev_q) begin
        // frame start: judge the gap that just ended
        count_q <= 5'h00;
        d0_high_q <= 1'b1;
        d03_high_q <= 1'b1;
        gap_ok_q <= (gap_q >= GAP_CYC);
      end else if (sclk_rise) begin
        if (count_q != `XMRC_CNT_MAX) begin
          count_q <= count_q + 5'h01; // saturates, long frames never wrap
        end
        d0_high_q <= d0_high_q & d0_s;
        d03_high_q <= d03_high_q & d0_s & d3_s;
      end
      if (!cs_n_s) begin
        gap_q <= 5'h00;
      end else if (gap_q != `XMRC_CNT_MAX) begin
        gap_q <= gap_q + 5'h01;
      end
    end
  end

endmodule

// *** xmrc_ctrl_monitor.sv ***
// concurrent checks on the xip mode and recovery controller ports
`timescale 1ns/1ps
module xmrc_ctrl_monitor #(
  parameter integer PWRUP_CYCLES = 20
) (
  input wire core_clk,
  input wire rst_n,
  input wire basic_xip_variant,
  input wire [2:0] nv_xip_sel,
  input wire vcr_wr_strobe,
  input wire vcr_wr_xip_n,
  input wire fast_read_active,
  input wire xip_active,
  input wire addr_only_mode,
  input wire [1:0] protocol,
  input wire vcr_xip_n,
  input wire xip_confirm_bit,
  input wire device_ready,
  input wire status_reads_only,
  input wire status_init_pulse
);
  // ----------------------------------------
  // cycles since reset release
  // ----------------------------------------
  reg [15:0] up_q;
  // saturates so a long run never wraps back into the power-up window
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      up_q <= 16'h0000;
    else if (up_q != 16'hffff)
      up_q <= up_q + 16'h0001;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_addr_only_xip: assert property (addr_only_mode == xip_active)
    else $error("address-only mode differs from xip state");
  a_reset_values: assert property ((up_q == 16'h0000) |->
    (!xip_active && vcr_xip_n && xip_confirm_bit && !device_ready
     && protocol == 2'h0))
    else $error("wrong state just after reset");
  a_ready_not_early: assert property ((up_q < PWRUP_CYCLES) |->
    !device_ready)
    else $error("ready before power-up delay");
  a_ready_in_time: assert property ((up_q == PWRUP_CYCLES + 5) |->
    device_ready)
    else $error("ready late after power-up");
  a_status_gate: assert property (status_reads_only == !device_ready)
    else $error("status-only gate wrong");
  a_init_pulse: assert property ($rose(device_ready) |->
    status_init_pulse ##1 !status_init_pulse)
    else $error("standby entry pulse wrong");
  a_exit_vcr: assert property ($fell(xip_active) |-> vcr_xip_n)
    else $error("xip exit left volatile bit low");
  a_entry_enabled: assert property ($rose(xip_active) |->
    (!xip_confirm_bit && (!$past(vcr_xip_n) || basic_xip_variant
     || nv_xip_sel != 3'h7)))
    else $error("xip entered without enable");
  a_vcr_write: assert property ((vcr_wr_strobe && device_ready &&
    !xip_active && !fast_read_active) |=> vcr_xip_n == $past(vcr_wr_xip_n))
    else $error("volatile bit write lost");
endmodule

bind xmrc_ctrl xmrc_ctrl_monitor #(.PWRUP_CYCLES(PWRUP_CYCLES)) mon (
  .core_clk(core_clk), .rst_n(rst_n), .basic_xip_variant(basic_xip_variant),
  .nv_xip_sel(nv_xip_sel), .vcr_wr_strobe(vcr_wr_strobe),
  .vcr_wr_xip_n(vcr_wr_xip_n), .fast_read_active(fast_read_active),
  .xip_active(xip_active), .addr_only_mode(addr_only_mode),
  .protocol(protocol), .vcr_xip_n(vcr_xip_n),
  .xip_confirm_bit(xip_confirm_bit), .device_ready(device_ready),
  .status_reads_only(status_reads_only),
  .status_init_pulse(status_init_pulse));

// *** xmrc_host_model.sv ***
// spi host model driving select, link clock and data lines
`timescale 1ns/1ps
module xmrc_host_model (
  input wire core_clk,
  output reg chip_select_n,
  output reg serial_clk,
  output reg serial_data_0,
  output reg serial_data_1,
  output reg serial_data_2,
  output reg hold_data_3
);
  integer i;
  // idle: deselected, clock parked low, data lines at a fixed mixed pattern
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    {serial_data_0, serial_data_1, serial_data_2, hold_data_3} = 4'h5;
  end
  // half link period, 80 ns
  task half;
    repeat (8) @(negedge core_clk);
  endtask
  // one frame of n clocks; d1 and d2 opposite d0 so they must be ignored
  task burst(input integer n, input reg d0, input reg d3);
    begin
      @(negedge core_clk);
      chip_select_n = 1'b0;
      {serial_data_0, serial_data_1, serial_data_2, hold_data_3} =
        {d0, ~d0, ~d0, d3};
      half;
      for (i = 0; i < n; i = i + 1) begin
        serial_clk = 1'b1;
        half;
        serial_clk = 1'b0;
        half;
      end
      chip_select_n = 1'b1;
      // released lines show the inverse, never a stale level
      {serial_data_0, serial_data_1, serial_data_2, hold_data_3} =
        {~d0, d0, d0, ~d3};
      repeat (20) @(negedge core_clk);
    end
  endtask
  // both rescue parts, in order
  task rescue;
    begin
      burst(7, 1'b1, 1'b1);
      burst(13, 1'b1, 1'b1);
      burst(25, 1'b1, 1'b1);
      burst(8, 1'b1, 1'b1);
    end
  endtask
  // hold select at a level without clocking
  task sel(input reg v);
    begin
      @(negedge core_clk);
      chip_select_n = v;
      repeat (10) @(negedge core_clk);
    end
  endtask
endmodule

// *** xmrc_ctrl_tb.sv ***
// self-checking bench for the xip mode and recovery controller
`timescale 1ns/1ps
module xmrc_ctrl_tb;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg hardware_reset_n = 1'b1;
  reg reset_pin_enable = 1'b0;
  reg basic_xip_variant = 1'b0;
  reg [2:0] nv_xip_sel = 3'h7;
  reg [1:0] nv_protocol_sel = 2'h0;
  reg vcr_wr_strobe = 1'b0;
  reg vcr_wr_xip_n = 1'b1;
  reg fast_read_active = 1'b0;
  reg first_dummy_cycle = 1'b0;
  wire cs_n, sclk, d0, d1, d2, d3;
  wire xip_active, addr_only_mode, vcr_xip_n, xip_confirm_bit;
  wire device_ready, status_reads_only, status_init_pulse, frame_sclk_rise;
  wire [1:0] protocol;
  integer n_fail = 0;
  integer check_count = 0;
  integer p;
  integer rises = 0;
  integer r0;
  reg [4:0] len [0:2];
  always #5 core_clk = ~core_clk;
  xmrc_host_model host (.core_clk(core_clk), .chip_select_n(cs_n),
    .serial_clk(sclk), .serial_data_0(d0), .serial_data_1(d1),
    .serial_data_2(d2), .hold_data_3(d3));
  // short power-up count keeps the run brief
  xmrc_ctrl #(.PWRUP_CYCLES(20)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .chip_select_n(cs_n), .serial_clk(sclk), .serial_data_0(d0),
    .serial_data_1(d1), .serial_data_2(d2), .hold_data_3(d3),
    .hardware_reset_n(hardware_reset_n), .reset_pin_enable(reset_pin_enable),
    .basic_xip_variant(basic_xip_variant), .nv_xip_sel(nv_xip_sel),
    .nv_protocol_sel(nv_protocol_sel), .vcr_wr_strobe(vcr_wr_strobe),
    .vcr_wr_xip_n(vcr_wr_xip_n), .fast_read_active(fast_read_active),
    .first_dummy_cycle(first_dummy_cycle), .xip_active(xip_active),
    .addr_only_mode(addr_only_mode), .protocol(protocol),
    .vcr_xip_n(vcr_xip_n), .xip_confirm_bit(xip_confirm_bit),
    .device_ready(device_ready), .status_reads_only(status_reads_only),
    .status_init_pulse(status_init_pulse), .frame_sclk_rise(frame_sclk_rise));
  // count synced link clock rises seen inside frames
  always @(posedge core_clk) begin
    if (frame_sclk_rise === 1'b1) begin
      rises <= rises + 1;
    end
  end
  // ----------------------------------------
  // compare, verdict and access tasks
  // ----------------------------------------
  task chk_n(input integer got, input integer exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
      end
    end
  endtask
  task chk(input [1:0] got, input [1:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("mismatches %0d, comparisons %0d", n_fail, check_count);
      if (n_fail == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // reset for three cycles, then wait for standby under a bound
  task do_reset;
    integer k;
    begin
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      chk({xip_active, device_ready}, 2'b00);
      chk({vcr_xip_n, status_reads_only}, 2'b11);
      rst_n = 1'b1;
      k = 0;
      while (device_ready !== 1'b1 && k < 100) begin
        @(negedge core_clk);
        k = k + 1;
      end
      chk({device_ready, status_reads_only}, 2'b10);
      chk({xip_confirm_bit, xip_active},
        (nv_xip_sel == 3'h7) ? 2'b10 : 2'b01);
      chk(protocol, nv_protocol_sel);
    end
  endtask
  // fast read carrying the confirm bit on its first dummy clock
  task confirm(input reg b);
    begin
      @(negedge core_clk);
      fast_read_active = 1'b1;
      first_dummy_cycle = 1'b1;
      host.burst(1, b, ~b);
      fast_read_active = 1'b0;
      first_dummy_cycle = 1'b0;
    end
  endtask
  task vcr_write(input reg v);
    begin
      @(negedge core_clk);
      vcr_wr_strobe = 1'b1;
      vcr_wr_xip_n = v;
      @(negedge core_clk);
      vcr_wr_strobe = 1'b0;
      @(negedge core_clk);
    end
  endtask
  task pin_pulse;
    begin
      @(negedge core_clk);
      hardware_reset_n = 1'b0;
      repeat (10) @(negedge core_clk);
      hardware_reset_n = 1'b1;
      repeat (30) @(negedge core_clk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    len[0] = 5'd25;
    len[1] = 5'd13;
    len[2] = 5'd7;
    do_reset;
    confirm(1'b0);
    chk({xip_active, vcr_xip_n}, 2'b01);
    vcr_write(1'b0);
    chk(vcr_xip_n, 1'b0);
    confirm(1'b0);
    chk({xip_active, addr_only_mode}, 2'b11);
    confirm(1'b0);
    chk({xip_active, xip_confirm_bit}, 2'b10);
    confirm(1'b1);
    chk({xip_active, vcr_xip_n}, 2'b01);
    chk(xip_confirm_bit, 1'b1);
    basic_xip_variant = 1'b1;
    do_reset;
    confirm(1'b0);
    chk({xip_active, vcr_xip_n}, 2'b11);
    basic_xip_variant = 1'b0;
    // boot in xip per protocol, near-miss count, exact count, rescue
    for (p = 0; p < 3; p = p + 1) begin
      nv_xip_sel = p;
      nv_protocol_sel = p;
      do_reset;
      host.burst(len[p] - 1, 1'b1, 1'b0);
      chk(xip_active, 1'b1);
      r0 = rises;
      host.burst(len[p], 1'b1, 1'b0);
      chk_n(rises - r0, len[p]);
      chk({xip_active, xip_confirm_bit}, 2'b01);
      chk({device_ready, vcr_xip_n}, 2'b11);
      chk(protocol, p);
      host.rescue;
      chk({xip_active, device_ready}, 2'b01);
      chk(protocol, 2'h0);
    end
    // enter xip again so the pin pulses have something to clear
    vcr_write(1'b0);
    confirm(1'b0);
    pin_pulse;
    chk(xip_active, 1'b1);
    reset_pin_enable = 1'b1;
    host.sel(1'b0);
    pin_pulse;
    host.sel(1'b1);
    chk(xip_active, 1'b1);
    // straps now say no xip, so the reload must leave it off
    nv_xip_sel = 3'h7;
    pin_pulse;
    chk({xip_active, xip_confirm_bit}, 2'b01);
    chk(protocol, 2'h2);
    chk({device_ready, vcr_xip_n}, 2'b11);
    complete_run;
  end
  // watchdog: the tests need about 5000 cycles, allow 20000
  initial begin
    #200000;
    n_fail = n_fail + 1;
    complete_run;
  end
endmodule
